// >>> vccr_pkg.sv
// Package for the voice codec control register bank: offsets, fields, reset values.
// Assumes one synchronous clock domain and 5-bit register addresses from the serial port.
package vccr_pkg;
  localparam logic [4:0] ADDR_ZERO = 5'h00;
  localparam logic [4:0] ADDR_CONTROL_ONE = 5'h01;
  localparam logic [4:0] ADDR_CONTROL_TWO = 5'h02;
  localparam logic [4:0] ADDR_PLL_INPUT_DIVIDER = 5'h03;
  localparam logic [4:0] ADDR_PLL_FEEDBACK_MULTIPLIER = 5'h04;
  localparam logic [4:0] ADDR_RECEIVE_INPUT_GAIN = 5'h05;
  localparam logic [4:0] ADDR_ADC_VOLUME = 5'h06;
  localparam logic [4:0] ADDR_DAC_VOLUME = 5'h07;
  localparam logic [4:0] ADDR_STATUS_REPORT = 5'h08;
  localparam logic [4:0] ADDR_ANALOG_ATTENUATION = 5'h09;

  localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
  localparam logic [7:0] RST_PLL_INPUT_DIVIDER = 8'h00;
  localparam logic [7:0] RST_PLL_FEEDBACK_MULTIPLIER = 8'h00;
  localparam logic [7:0] RST_RECEIVE_INPUT_GAIN = 8'h47;
  localparam logic [7:0] RST_ADC_VOLUME = 8'h5C;
  localparam logic [7:0] RST_DAC_VOLUME = 8'h5C;
  localparam logic [7:0] RST_ANALOG_ATTENUATION = 8'h00;

  // Writable bit masks, plus the read-only status flag mask; reserved bits are held at zero
  localparam logic [7:0] MASK_CONTROL_ONE = 8'h1F;
  localparam logic [7:0] MASK_CONTROL_TWO = 8'h1E;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_VOLUME = 8'h7F;
  localparam logic [7:0] MASK_STATUS = 8'hE0;
  localparam logic [7:0] MASK_ANALOG_ATTENUATION = 8'h0F;

  localparam int SOFT_RESET_BIT = 7;
  localparam int SPEAKER_DRIVER_ON_BIT = 4;
  localparam int LINE_DRIVER_ON_BIT = 3;
  localparam int HANDSET_DRIVER_ON_BIT = 2;
  localparam int MIC_BIAS_OFF_BIT = 1;
  localparam int CHIP_SLEEP_BIT = 0;
  localparam int HIGHPASS_DISABLE_BIT = 4;
  localparam int PLL_DIV10_BIT = 3;
  localparam int ANALOG_LOOPBACK_BIT = 2;
  localparam int BITSTREAM_LOOPBACK_BIT = 1;
  localparam int LINE_IN_MUTE_BIT = 5;
  localparam int MICROPHONE_MUTE_BIT = 2;
  localparam int HANDSET_IN_MUTE_BIT = 1;
  localparam int IIR_SELECT_BIT = 0;
  localparam int LINE_OUT_ACTIVE_BIT = 1;
  localparam int HANDSET_OUT_ACTIVE_BIT = 0;
  localparam logic [1:0] LINE_IN_GAIN_RESERVED = 2'h0;
  localparam logic [3:0] PLL_FINAL_DIV_TEN = 4'hA;
  localparam logic [3:0] PLL_FINAL_DIV_FIVE = 4'h5;

  typedef struct packed {
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } vccr_access_t;

  typedef struct packed {
    logic speaker_driver_on;
    logic line_driver_on;
    logic handset_driver_on;
    logic mic_bias_off;
    logic chip_sleep;
    logic highpass_disable;
    logic [3:0] pll_final_div;
    logic analog_loopback_en;
    logic bitstream_loopback_en;
    logic [8:0] pll_input_div;
    logic [8:0] pll_feedback_mult;
    logic pll_bypass;
    logic [1:0] line_in_gain;
    logic line_in_gain_bad;
    logic line_in_mute;
    logic [1:0] microphone_gain;
    logic microphone_mute;
    logic handset_in_mute;
    logic iir_select;
    logic [4:0] receive_pga_gain;
    logic line_out_active;
    logic handset_out_active;
    logic [4:0] transmit_pga_gain;
    logic left_speaker_active;
    logic right_speaker_active;
    logic [1:0] line_out_attenuation;
    logic [1:0] speaker_out_attenuation;
  } vccr_ctrl_t;
endpackage : vccr_pkg

// >>> vccr_regs.sv
// Control register bank of the voiceband codec, one access per secondary frame.
// Assumes the serial port deframes accesses into a one-cycle strobe on i_sys_clk.
//
// Contract
// - Address zero reads zero; writes to it change nothing.
// - Soft reset bit restores all registers, then clears itself.
// - Speaker, line, handset driver bits power down when zero.
// - Mic bias buffer bit powers down when set.
// - Chip sleep bit set puts whole chip in power down.
// - High-pass disable bit set disables filter.
// - PLL final divider bit: one divides by ten, zero by five.
// - Analog loopback enable routes DAC analog out to ADC in.
// - Bitstream loopback enable routes DAC bitstream to ADC bitstream.
// - PLL input divider is eight bits; divisor is value plus one.
// - PLL feedback multiplier is eight bits; multiplier is value plus one.
// - Line input gain field and mute bit; code zero reserved.
// - Microphone gain field zero to thirty dB and mute bit.
// - Handset input mute bit set mutes handset input.
// - Filter select bit: one IIR, zero FIR.
// - Receive PGA gain five-bit field, 1.5 dB steps.
// - Line and handset output active bits; zero mutes.
// - Each access has read flag, five-bit address, eight-bit data.
// - Both PLL registers zero bypasses the PLL.
`timescale 1ns/10ps
`default_nettype none
module vccr_regs (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_reset_n,
  input wire logic i_access_valid,
  input wire vccr_pkg::vccr_access_t i_access,
  input wire logic [2:0] i_short_status,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  output vccr_pkg::vccr_ctrl_t o_ctrl
);

  localparam int NREG = 10;

  logic [7:0] regs_reg [NREG];
  logic [7:0] regs_next [NREG];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rdata_valid_reg;
  logic rdata_valid_next;
  logic soft_reset;

  function automatic logic [7:0] write_mask(input logic [4:0] addr);
    case (addr)
      vccr_pkg::ADDR_CONTROL_ONE: write_mask = vccr_pkg::MASK_CONTROL_ONE;
      vccr_pkg::ADDR_CONTROL_TWO: write_mask = vccr_pkg::MASK_CONTROL_TWO;
      vccr_pkg::ADDR_PLL_INPUT_DIVIDER: write_mask = vccr_pkg::MASK_FULL;
      vccr_pkg::ADDR_PLL_FEEDBACK_MULTIPLIER: write_mask = vccr_pkg::MASK_FULL;
      vccr_pkg::ADDR_RECEIVE_INPUT_GAIN: write_mask = vccr_pkg::MASK_FULL;
      vccr_pkg::ADDR_ADC_VOLUME: write_mask = vccr_pkg::MASK_VOLUME;
      vccr_pkg::ADDR_DAC_VOLUME: write_mask = vccr_pkg::MASK_VOLUME;
      vccr_pkg::ADDR_ANALOG_ATTENUATION: write_mask = vccr_pkg::MASK_ANALOG_ATTENUATION;
      default: write_mask = 8'h00;
    endcase
  endfunction : write_mask

  function automatic logic [7:0] reset_value(input int idx);
    case (idx)
      1: reset_value = vccr_pkg::RST_CONTROL_ONE;
      2: reset_value = vccr_pkg::RST_CONTROL_TWO;
      3: reset_value = vccr_pkg::RST_PLL_INPUT_DIVIDER;
      4: reset_value = vccr_pkg::RST_PLL_FEEDBACK_MULTIPLIER;
      5: reset_value = vccr_pkg::RST_RECEIVE_INPUT_GAIN;
      6: reset_value = vccr_pkg::RST_ADC_VOLUME;
      7: reset_value = vccr_pkg::RST_DAC_VOLUME;
      9: reset_value = vccr_pkg::RST_ANALOG_ATTENUATION;
      default: reset_value = 8'h00;
    endcase
  endfunction : reset_value

  // The soft reset bit is never stored, so it reads back clear at once
  assign soft_reset = i_access_valid && !i_access.rd &&
                      (i_access.addr == vccr_pkg::ADDR_CONTROL_ONE) &&
                      i_access.wdata[vccr_pkg::SOFT_RESET_BIT];

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      always_comb begin
        regs_next[g] = regs_reg[g];
        if (soft_reset) begin
          regs_next[g] = reset_value(g);
        end else if (g == int'(vccr_pkg::ADDR_STATUS_REPORT)) begin
          // Live short-circuit flags from the analog drivers
          regs_next[g] = {i_short_status, 5'h00} & vccr_pkg::MASK_STATUS;
        end else if (i_access_valid && !i_access.rd && (i_access.addr == 5'(g))) begin
          // Reserved bits and address zero are masked off
          regs_next[g] = i_access.wdata & write_mask(5'(g));
        end
      end
      always_ff @(posedge i_sys_clk) begin
        if (i_srst || !i_reset_n) begin
          regs_reg[g] <= reset_value(g);
        end else begin
          regs_reg[g] <= regs_next[g];
        end
      end
    end
  endgenerate

  always_comb begin
    rdata_next = rdata_reg;
    rdata_valid_next = 1'b0;
    if (i_access_valid && i_access.rd) begin
      rdata_valid_next = 1'b1;
      if (i_access.addr < 5'(NREG)) begin
        rdata_next = regs_reg[i_access.addr[3:0]] & write_mask(i_access.addr);
        if (i_access.addr == vccr_pkg::ADDR_STATUS_REPORT) begin
          rdata_next = regs_reg[i_access.addr[3:0]];
        end
      end else begin
        // Undefined addresses read as zero; the host should not touch them
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !i_reset_n) begin
      rdata_reg <= 8'h00;
      rdata_valid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rdata_valid_reg <= rdata_valid_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rdata_valid = rdata_valid_reg;

  always_comb begin
    o_ctrl.speaker_driver_on = regs_reg[1][vccr_pkg::SPEAKER_DRIVER_ON_BIT];
    o_ctrl.line_driver_on = regs_reg[1][vccr_pkg::LINE_DRIVER_ON_BIT];
    o_ctrl.handset_driver_on = regs_reg[1][vccr_pkg::HANDSET_DRIVER_ON_BIT];
    o_ctrl.mic_bias_off = regs_reg[1][vccr_pkg::MIC_BIAS_OFF_BIT];
    o_ctrl.chip_sleep = regs_reg[1][vccr_pkg::CHIP_SLEEP_BIT];
    o_ctrl.highpass_disable = regs_reg[2][vccr_pkg::HIGHPASS_DISABLE_BIT];
    o_ctrl.pll_final_div = regs_reg[2][vccr_pkg::PLL_DIV10_BIT] ?
                           vccr_pkg::PLL_FINAL_DIV_TEN : vccr_pkg::PLL_FINAL_DIV_FIVE;
    o_ctrl.analog_loopback_en = regs_reg[2][vccr_pkg::ANALOG_LOOPBACK_BIT];
    o_ctrl.bitstream_loopback_en = regs_reg[2][vccr_pkg::BITSTREAM_LOOPBACK_BIT];
    o_ctrl.pll_input_div = {1'b0, regs_reg[3]} + 9'h001;
    o_ctrl.pll_feedback_mult = {1'b0, regs_reg[4]} + 9'h001;
    // Writing both halves between updates may briefly bypass; the host orders them
    o_ctrl.pll_bypass = (regs_reg[3] == 8'h00) && (regs_reg[4] == 8'h00);
    o_ctrl.line_in_gain = regs_reg[5][7:6];
    o_ctrl.line_in_gain_bad = (regs_reg[5][7:6] == vccr_pkg::LINE_IN_GAIN_RESERVED);
    o_ctrl.line_in_mute = regs_reg[5][vccr_pkg::LINE_IN_MUTE_BIT];
    o_ctrl.microphone_gain = regs_reg[5][4:3];
    o_ctrl.microphone_mute = regs_reg[5][vccr_pkg::MICROPHONE_MUTE_BIT];
    o_ctrl.handset_in_mute = regs_reg[5][vccr_pkg::HANDSET_IN_MUTE_BIT];
    o_ctrl.iir_select = regs_reg[5][vccr_pkg::IIR_SELECT_BIT];
    o_ctrl.receive_pga_gain = regs_reg[6][6:2];
    o_ctrl.line_out_active = regs_reg[6][vccr_pkg::LINE_OUT_ACTIVE_BIT];
    o_ctrl.handset_out_active = regs_reg[6][vccr_pkg::HANDSET_OUT_ACTIVE_BIT];
    o_ctrl.transmit_pga_gain = regs_reg[7][6:2];
    o_ctrl.left_speaker_active = regs_reg[7][1];
    o_ctrl.right_speaker_active = regs_reg[7][0];
    o_ctrl.line_out_attenuation = regs_reg[9][3:2];
    o_ctrl.speaker_out_attenuation = regs_reg[9][1:0];
  end

endmodule : vccr_regs
`default_nettype wire

// >>> vccr_host_model.sv
// Host side of the serial port: one register access per secondary frame.
// Assumes the register bank answers a read one clock after the strobe.
`timescale 1ns/10ps
`default_nettype none
module vccr_host_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_valid,
  output logic o_valid,
  output vccr_pkg::vccr_access_t o_access
);
  initial begin
    o_valid = 1'b0;
    o_access = '0;
  end
  // Callers may pass undefined addresses and set reserved bits; the bank masks them
  task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    @(posedge i_sys_clk);
    o_valid <= 1'b1;
    o_access <= '{rd: rd, addr: a, wdata: d};
    @(posedge i_sys_clk);
    o_valid <= 1'b0;
    // Released data is scrambled so no stale byte looks valid
    o_access <= '{rd: ~rd, addr: ~a, wdata: ~d};
    #1;
    q = i_rdata;
    ok = (i_rdata_valid === rd);
  endtask : xfer
endmodule : vccr_host_model
`default_nettype wire

// >>> vccr_regs_asserts.sv
// Port-level checks for the control register bank.
// Assumes one clock and either reset source disabling every check.
`timescale 1ns/10ps
`default_nettype none
module vccr_regs_asserts (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_reset_n,
  input wire logic i_access_valid,
  input wire vccr_pkg::vccr_access_t i_access,
  input wire logic [2:0] i_short_status,
  input wire logic [7:0] o_rdata,
  input wire logic o_rdata_valid,
  input wire vccr_pkg::vccr_ctrl_t o_ctrl
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst || !i_reset_n);
  wire logic rd_go = i_access_valid && i_access.rd;
  wire logic wr_go = i_access_valid && !i_access.rd;
  a_read_answer: assert property (rd_go |=> o_rdata_valid)
    else $error("read not answered");
  a_no_stray: assert property (!rd_go |=> !o_rdata_valid)
    else $error("stray read valid");
  a_zero_reads: assert property (rd_go && i_access.addr == 5'h00 |=> o_rdata == 8'h00)
    else $error("address zero not zero");
  a_reserved_zero: assert property (rd_go && i_access.addr == 5'h01 |=> o_rdata[6:5] == 2'h0)
    else $error("reserved bits set");
  a_sleep_follows: assert property (wr_go && i_access.addr == 5'h01 && !i_access.wdata[7]
    |=> o_ctrl.chip_sleep == $past(i_access.wdata[0]))
    else $error("sleep bit wrong");
  a_soft_restore: assert property (wr_go && i_access.addr == 5'h01 && i_access.wdata[7]
    |=> o_ctrl.receive_pga_gain == 5'h17 && o_ctrl.line_in_gain == 2'h1)
    else $error("soft reset incomplete");
  a_final_div: assert property (wr_go && i_access.addr == 5'h02
    |=> o_ctrl.pll_final_div == ($past(i_access.wdata[3]) ? 4'hA : 4'h5))
    else $error("final divider wrong");
  a_div_plus_one: assert property (wr_go && i_access.addr == 5'h03
    |=> o_ctrl.pll_input_div == {1'b0, $past(i_access.wdata)} + 9'h001)
    else $error("input divisor wrong");
  a_soft_clears: assert property (rd_go && i_access.addr == 5'h01 |=> o_rdata[7] == 1'b0)
    else $error("soft reset bit read back set");
  a_pll_bypass: assert property (o_ctrl.pll_bypass ==
    (o_ctrl.pll_input_div == 9'h001 && o_ctrl.pll_feedback_mult == 9'h001))
    else $error("bypass decode wrong");
endmodule : vccr_regs_asserts
bind vccr_regs vccr_regs_asserts u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
  .i_reset_n(i_reset_n), .i_access_valid(i_access_valid), .i_access(i_access),
  .i_short_status(i_short_status), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
  .o_ctrl(o_ctrl));
`default_nettype wire

// >>> vccr_regs_bench.sv
// Self-checking bench for the control register bank.
// Assumes the host model issues every access; reset values follow the table.
`timescale 1ns/10ps
`default_nettype none
module vccr_regs_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rst_n = 1'b1;
  logic vld;
  logic rv;
  logic [2:0] sh = 3'h0;
  logic [7:0] rdat;
  vccr_pkg::vccr_access_t acc;
  vccr_pkg::vccr_ctrl_t c;
  int miscompares = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  vccr_host_model host (.i_sys_clk(clk), .i_rdata(rdat), .i_rdata_valid(rv),
    .o_valid(vld), .o_access(acc));
  vccr_regs dut (.i_sys_clk(clk), .i_srst(srst), .i_reset_n(rst_n), .i_access_valid(vld),
    .i_access(acc), .i_short_status(sh), .o_rdata(rdat), .o_rdata_valid(rv), .o_ctrl(c));
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  task automatic cmp(input string n, input logic [8:0] s, input logic [8:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    host.xfer(1'b0, a, d, q, ok);
  endtask : wr
  // Valid flag rides as the top bit so a missing answer also mismatches
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    host.xfer(1'b1, a, 8'h00, q, ok);
    cmp("readback", {ok, q}, {1'b1, e});
  endtask : rdc
  task automatic t_reset;
    logic [7:0] rv_tab [0:9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h47, 8'h5C, 8'h5C,
      8'h00, 8'h00};
    for (int i = 0; i < 10; i++) rdc(5'(i), rv_tab[i]);
    rdc(5'h1F, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fields;
    wr(5'h01, 8'h0A);
    cmp("ctl1", 9'({c.speaker_driver_on, c.line_driver_on, c.handset_driver_on,
      c.mic_bias_off, c.chip_sleep}), 9'h00A);
    wr(5'h00, 8'hFF);
    rdc(5'h00, 8'h00);
    rdc(5'h01, 8'h0A);
    // Opposite pattern so a stuck driver or sleep bit cannot hide
    wr(5'h01, 8'h15);
    cmp("ctl1b", 9'({c.speaker_driver_on, c.line_driver_on, c.handset_driver_on,
      c.mic_bias_off, c.chip_sleep}), 9'h015);
    wr(5'h02, 8'h1A);
    cmp("ctl2", 9'({c.highpass_disable, c.pll_final_div, c.analog_loopback_en,
      c.bitstream_loopback_en}), 9'h069);
    wr(5'h02, 8'h04);
    cmp("ctl2b", 9'({c.highpass_disable, c.pll_final_div, c.analog_loopback_en,
      c.bitstream_loopback_en}), 9'h016);
    wr(5'h05, 8'hBD);
    cmp("gain", {c.line_in_gain, c.line_in_gain_bad, c.line_in_mute, c.microphone_gain,
      c.microphone_mute, c.handset_in_mute, c.iir_select}, 9'h13D);
    wr(5'h05, 8'h3A);
    cmp("gainb", {c.line_in_gain, c.line_in_gain_bad, c.line_in_mute, c.microphone_gain,
      c.microphone_mute, c.handset_in_mute, c.iir_select}, 9'h07A);
    wr(5'h06, 8'h63);
    cmp("vol", 9'({c.receive_pga_gain, c.line_out_active, c.handset_out_active}),
      9'h063);
    $display("t_fields done");
  endtask : t_fields
  task automatic t_pll;
    wr(5'h03, 8'h00);
    wr(5'h04, 8'h00);
    cmp("bypass", 9'(c.pll_bypass), 9'h001);
    wr(5'h03, 8'hFF);
    wr(5'h04, 8'h01);
    cmp("ndiv", c.pll_input_div, 9'h100);
    cmp("mmul", c.pll_feedback_mult, 9'h002);
    cmp("nobypass", 9'(c.pll_bypass), 9'h000);
    $display("t_pll done");
  endtask : t_pll
  task automatic t_soft;
    wr(5'h01, 8'h80);
    rdc(5'h01, 8'h00);
    rdc(5'h05, 8'h47);
    rdc(5'h06, 8'h5C);
    rdc(5'h03, 8'h00);
    @(posedge clk) sh <= 3'h5;
    wr(5'h08, 8'h00);
    rdc(5'h08, 8'hA0);
    wr(5'h05, 8'h60);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    rdc(5'h05, 8'h47);
    $display("t_soft done");
  endtask : t_soft
  // Speaker volume and attenuation fields, decoded and read back
  task automatic t_speaker;
    wr(5'h07, 8'h6E);
    cmp("dac", 9'({c.transmit_pga_gain, c.left_speaker_active, c.right_speaker_active}),
      9'h06E);
    rdc(5'h07, 8'h6E);
    wr(5'h09, 8'h09);
    cmp("atten", 9'({c.line_out_attenuation, c.speaker_out_attenuation}), 9'h009);
    rdc(5'h09, 8'h09);
    $display("t_speaker done");
  endtask : t_speaker
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_fields();
    t_pll();
    t_speaker();
    t_soft();
    final_report();
  end
endmodule : vccr_regs_bench
`default_nettype wire
